// ===== ddrc_bank_timer.sv
// Per-bank busy timer counting CK cycles until the bank accepts ACTIVE
`timescale 1ns/100ps
`default_nettype none
module ddrc_bank_timer
	import ddrc_pkg::*;
(
	input wire logic i_ref_clk, // System clock
	input wire logic i_rst_n, // Async reset, active low
	input wire logic i_tick, // One CK cycle elapsed
	input wire logic i_load, // Load a busy count
	input wire logic [3:0] i_count, // Busy count minus one
	output logic o_idle // Bank free for ACTIVE
);

	logic [3:0] cnt_r;
	logic [3:0] cnt_nxt;

	// ==========================================================
	// Longer load wins over the running count
	always_comb
	begin
		cnt_nxt = cnt_r;
		if (i_tick && cnt_r != 4'h0)
			cnt_nxt = cnt_r - 4'h1;
		if (i_load && i_count > cnt_nxt)
			cnt_nxt = i_count;
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			cnt_r <= 4'h0;
		else
			cnt_r <= cnt_nxt;
	end

	assign o_idle = (cnt_r == 4'h0);

endmodule
`default_nettype wire

// ===== ddrc_cfg.svh
// Timing counts, mode words and field positions of the DDR command controller
`ifndef DDRC_CFG_SVH
`define DDRC_CFG_SVH

// ==========================================================
// Clock rates
`define DDRC_REF_NS 50
`define DDRC_CK_DIV 2
`define DDRC_CK_NS (`DDRC_REF_NS * `DDRC_CK_DIV)
`define DDRC_MIN_CK(t) (((t) + `DDRC_CK_NS - 1) / `DDRC_CK_NS)
`define DDRC_MAX_CK(t) ((t) / `DDRC_CK_NS)

// ==========================================================
// Device times in ns
`define DDRC_T_RCD_NS 15
`define DDRC_T_RRD_NS 10
`define DDRC_T_RFC_NS 70
`define DDRC_T_WTR_NS 10
`define DDRC_T_MRD_NS 10
`define DDRC_T_WR_NS 15
`define DDRC_T_RP_NS 15
`define DDRC_T_RC_NS 55
`define DDRC_T_PWRUP_NS 200000
`define DDRC_T_REFI_85_NS 1950
`define DDRC_T_REFI_95_NS 3900
`define DDRC_T_REFI_105_NS 7800

// ==========================================================
// Counts in CK cycles, plus the number of start-up AUTO REFRESH commands
`define DDRC_RCD_CK `DDRC_MIN_CK(`DDRC_T_RCD_NS)
`define DDRC_RFC_CK `DDRC_MIN_CK(`DDRC_T_RFC_NS)
`define DDRC_WTR_CK `DDRC_MIN_CK(`DDRC_T_WTR_NS)
`define DDRC_MRD_CK `DDRC_MIN_CK(`DDRC_T_MRD_NS)
`define DDRC_WR_CK `DDRC_MIN_CK(`DDRC_T_WR_NS)
`define DDRC_RP_CK `DDRC_MIN_CK(`DDRC_T_RP_NS)
`define DDRC_RC_CK `DDRC_MIN_CK(`DDRC_T_RC_NS)
`define DDRC_PWRUP_CK `DDRC_MIN_CK(`DDRC_T_PWRUP_NS)
`define DDRC_REFI_85_CK `DDRC_MAX_CK(`DDRC_T_REFI_85_NS)
`define DDRC_REFI_95_CK `DDRC_MAX_CK(`DDRC_T_REFI_95_NS)
`define DDRC_REFI_105_CK `DDRC_MAX_CK(`DDRC_T_REFI_105_NS)
`define DDRC_XSRD_CK 200
`define DDRC_XSNR_CK 75
`define DDRC_DLL_CK 200
`define DDRC_INIT_REFS 2
`define DDRC_DQSS_CK 1
`define DDRC_BL_CK 1
`define DDRC_DAL_CK (`DDRC_WR_CK + `DDRC_RP_CK)
`define DDRC_WR_BUSY_CK (`DDRC_DQSS_CK + `DDRC_BL_CK + `DDRC_DAL_CK)
`define DDRC_RD_BUSY_CK (`DDRC_BL_CK + `DDRC_RP_CK)
`define DDRC_WTR_TOT_CK (`DDRC_DQSS_CK + `DDRC_BL_CK + `DDRC_WTR_CK)

// ==========================================================
// Address fields and mode words
`define DDRC_A10 10
`define DDRC_A8 8
`define DDRC_MODE_OP 12'h021
`define DDRC_MODE_DLL_RST 12'h121
`define DDRC_EMODE_DLL_ON 12'h000
`define DDRC_BA_MODE 2'h0
`define DDRC_BA_EMODE 2'h1

`endif

// ===== ddrc_ctrl.sv
// DDR SDRAM command controller: power-up sequence and command spacing
//
// What this block does
// - Waits tRCD after ACTIVE before READ or WRITE to that bank.
// - Keeps ACTIVE commands to different banks tRRD apart.
// - Waits tRFC after AUTO REFRESH before ACTIVE or refresh.
// - Waits tWTR after the last write data pair before a READ.
// - Waits tMRD after any mode register set command.
// - Write with auto precharge holds the bank for tWR plus tRP.
// - No READ until 200 CK cycles after self refresh exit.
// - No other command until 75 CK cycles after self refresh exit.
// - Power-up holds CKE low with NOP and a running clock 200 us.
// - Then NOP with CKE raised, followed by PRECHARGE ALL.
// - Next an extended mode set enabling the DLL.
// - Mode set resetting the DLL, then 200 CK cycles to lock.
// - Then all banks are precharged again.
// - Then at least two AUTO REFRESH commands.
// - Ends with a mode set having A8 low.
`timescale 1ns/100ps
`default_nettype none
`include "ddrc_cfg.svh"
module ddrc_ctrl
	import ddrc_pkg::*;
(
	input wire logic i_ref_clk, // 20 MHz system clock
	input wire logic i_rst_n, // Async reset, active low
	input wire logic i_req_valid, // Access request
	input wire logic i_req_write, // 1 write, 0 read
	input wire logic [1:0] i_req_bank, // Bank address
	input wire logic [11:0] i_req_row, // Row address
	input wire logic [7:0] i_req_col, // Column address
	output logic o_req_ready, // Request taken this cycle
	input wire logic i_sr_req, // Hold device in self refresh
	input wire logic [1:0] i_temp_range, // 0 <=85C, 1 <=95C, else <=105C
	output logic o_init_done, // Initialization complete
	output logic o_self_refresh, // Device in self refresh
	output logic o_ck, // Device clock
	output logic o_ck_n, // Device clock, inverted
	output logic o_cke, // Clock enable
	output logic o_cs_n, // Chip select, active low
	output logic o_ras_n, // Row strobe, active low
	output logic o_cas_n, // Column strobe, active low
	output logic o_we_n, // Write enable, active low
	output logic [1:0] o_ba, // Bank address
	output logic [11:0] o_addr // Address
);

	// ==========================================================
	// Clock divider: commands change on falling CK
	logic ck_r;
	logic ckn_r;
	logic ck_en;

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			ck_r <= 1'b0;
			ckn_r <= 1'b1;
		end
		else
		begin
			ck_r <= ~ck_r;
			ckn_r <= ck_r;
		end
	end

	assign ck_en = ck_r;
	assign o_ck = ck_r;
	assign o_ck_n = ckn_r;

	// ==========================================================
	// Sequencer state
	ddrc_state_t state_r, state_nxt;
	ddrc_cmd_t cmd_r, cmd_nxt;
	logic [11:0] wait_r, wait_nxt;
	logic [11:0] addr_r, addr_nxt;
	logic [1:0] ba_r, ba_nxt;
	logic cke_r, cke_nxt;
	logic init_r, init_nxt;
	logic [1:0] refs_r, refs_nxt;
	logic rq_wr_r, rq_wr_nxt;
	logic [7:0] rq_col_r, rq_col_nxt;
	logic [1:0] wtr_r, wtr_nxt;
	logic [7:0] xsrd_r, xsrd_nxt;
	logic [7:0] refi_r, refi_nxt;
	logic pend_r, pend_nxt;
	logic [3:0] bank_idle;
	logic [3:0] bank_load;
	logic [3:0] bank_cnt;
	logic take;
	logic ref_clr;

	function automatic logic [7:0] refi_load(input logic [1:0] rng);
		case (rng)
			2'h0: refi_load = 8'(`DDRC_REFI_85_CK - 1);
			2'h1: refi_load = 8'(`DDRC_REFI_95_CK - 1);
			default: refi_load = 8'(`DDRC_REFI_105_CK - 1);
		endcase
	endfunction

	assign take = ck_en && state_r == ST_IDLE && wait_r == 12'h000 &&
		!pend_r && !i_sr_req && i_req_valid && bank_idle[i_req_bank] &&
		(i_req_write || (wtr_r == 2'h0 && xsrd_r == 8'h00));
	assign o_req_ready = take;

	always_comb
	begin
		state_nxt = state_r;
		cmd_nxt = cmd_r;
		wait_nxt = wait_r;
		addr_nxt = addr_r;
		ba_nxt = ba_r;
		cke_nxt = cke_r;
		init_nxt = init_r;
		refs_nxt = refs_r;
		rq_wr_nxt = rq_wr_r;
		rq_col_nxt = rq_col_r;
		wtr_nxt = wtr_r;
		xsrd_nxt = xsrd_r;
		bank_load = 4'h0;
		bank_cnt = 4'h0;
		ref_clr = 1'b0;
		if (ck_en)
		begin
			cmd_nxt = CMD_NOP;
			if (wtr_r != 2'h0)
				wtr_nxt = wtr_r - 2'h1;
			if (xsrd_r != 8'h00)
				xsrd_nxt = xsrd_r - 8'h01;
			if (wait_r != 12'h000)
				wait_nxt = wait_r - 12'h001;
			else
			begin
				case (state_r)
					ST_PWRUP:
					begin
						cke_nxt = 1'b1;
						state_nxt = ST_PRE1;
					end
					ST_PRE1:
					begin
						cmd_nxt = CMD_PRE;
						addr_nxt = 12'h000;
						addr_nxt[`DDRC_A10] = 1'b1;
						wait_nxt = 12'(`DDRC_RP_CK - 1);
						state_nxt = ST_EMRS;
					end
					ST_EMRS:
					begin
						cmd_nxt = CMD_MRS;
						ba_nxt = `DDRC_BA_EMODE;
						addr_nxt = `DDRC_EMODE_DLL_ON;
						wait_nxt = 12'(`DDRC_MRD_CK - 1);
						state_nxt = ST_MRS_DLL;
					end
					ST_MRS_DLL:
					begin
						cmd_nxt = CMD_MRS;
						ba_nxt = `DDRC_BA_MODE;
						addr_nxt = `DDRC_MODE_DLL_RST;
						wait_nxt = 12'(`DDRC_DLL_CK - 1);
						state_nxt = ST_PRE2;
					end
					ST_PRE2:
					begin
						cmd_nxt = CMD_PRE;
						addr_nxt = 12'h000;
						addr_nxt[`DDRC_A10] = 1'b1;
						wait_nxt = 12'(`DDRC_RP_CK - 1);
						refs_nxt = 2'(`DDRC_INIT_REFS - 1);
						state_nxt = ST_REF;
					end
					ST_REF:
					begin
						cmd_nxt = CMD_AR;
						wait_nxt = 12'(`DDRC_RFC_CK - 1);
						if (refs_r == 2'h0)
							state_nxt = ST_MRS_OP;
						else
							refs_nxt = refs_r - 2'h1;
					end
					ST_MRS_OP:
					begin
						cmd_nxt = CMD_MRS;
						ba_nxt = `DDRC_BA_MODE;
						addr_nxt = `DDRC_MODE_OP;
						wait_nxt = 12'(`DDRC_MRD_CK - 1);
						init_nxt = 1'b1;
						state_nxt = ST_IDLE;
					end
					ST_IDLE:
					begin
						if (pend_r && bank_idle == 4'hF)
						begin
							cmd_nxt = CMD_AR;
							ref_clr = 1'b1;
							wait_nxt = 12'(`DDRC_RFC_CK - 1);
						end
						else if (i_sr_req && bank_idle == 4'hF)
						begin
							cmd_nxt = CMD_AR;
							cke_nxt = 1'b0;
							state_nxt = ST_SR;
						end
						else if (take)
						begin
							cmd_nxt = CMD_ACT;
							ba_nxt = i_req_bank;
							addr_nxt = i_req_row;
							rq_wr_nxt = i_req_write;
							rq_col_nxt = i_req_col;
							wait_nxt = 12'(`DDRC_RCD_CK - 1);
							bank_load[i_req_bank] = 1'b1;
							bank_cnt = 4'(`DDRC_RC_CK - 1);
							state_nxt = ST_RW;
						end
					end
					ST_RW:
					begin
						cmd_nxt = rq_wr_r ? CMD_WR : CMD_RD;
						addr_nxt = {4'h0, rq_col_r};
						addr_nxt[`DDRC_A10] = 1'b1;
						bank_load[ba_r] = 1'b1;
						if (rq_wr_r)
						begin
							bank_cnt = 4'(`DDRC_WR_BUSY_CK - 1);
							wtr_nxt = 2'(`DDRC_WTR_TOT_CK);
						end
						else
							bank_cnt = 4'(`DDRC_RD_BUSY_CK - 1);
						state_nxt = ST_IDLE;
					end
					ST_SR:
					begin
						if (!i_sr_req)
						begin
							cke_nxt = 1'b1;
							wait_nxt = 12'(`DDRC_XSNR_CK - 1);
							xsrd_nxt = 8'(`DDRC_XSRD_CK - 1);
							state_nxt = ST_IDLE;
						end
					end
					default:
						state_nxt = ST_PWRUP;
				endcase
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state_r <= ST_PWRUP;
			cmd_r <= CMD_NOP;
			wait_r <= 12'(`DDRC_PWRUP_CK - 1);
			addr_r <= 12'h000;
			ba_r <= 2'h0;
			cke_r <= 1'b0;
			init_r <= 1'b0;
			refs_r <= 2'h0;
			rq_wr_r <= 1'b0;
			rq_col_r <= 8'h00;
			wtr_r <= 2'h0;
			xsrd_r <= 8'h00;
		end
		else
		begin
			state_r <= state_nxt;
			cmd_r <= cmd_nxt;
			wait_r <= wait_nxt;
			addr_r <= addr_nxt;
			ba_r <= ba_nxt;
			cke_r <= cke_nxt;
			init_r <= init_nxt;
			refs_r <= refs_nxt;
			rq_wr_r <= rq_wr_nxt;
			rq_col_r <= rq_col_nxt;
			wtr_r <= wtr_nxt;
			xsrd_r <= xsrd_nxt;
		end
	end

	// ==========================================================
	// Refresh interval: free-running, so the average stays bounded
	always_comb
	begin
		refi_nxt = refi_r;
		pend_nxt = pend_r & ~ref_clr;
		if (ck_en)
		begin
			if (refi_r == 8'h00)
			begin
				refi_nxt = refi_load(i_temp_range);
				pend_nxt = 1'b1;
			end
			else
				refi_nxt = refi_r - 8'h01;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			refi_r <= 8'(`DDRC_REFI_85_CK - 1);
			pend_r <= 1'b0;
		end
		else
		begin
			refi_r <= refi_nxt;
			pend_r <= pend_nxt;
		end
	end

	// ==========================================================
	// Bank timers
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_bank
			ddrc_bank_timer u_timer (
				.i_ref_clk(i_ref_clk),
				.i_rst_n(i_rst_n),
				.i_tick(ck_en),
				.i_load(bank_load[gi]),
				.i_count(bank_cnt),
				.o_idle(bank_idle[gi])
			);
		end
	endgenerate

	assign {o_cs_n, o_ras_n, o_cas_n, o_we_n} = cmd_r;
	assign o_cke = cke_r;
	assign o_ba = ba_r;
	assign o_addr = addr_r;
	assign o_init_done = init_r;
	assign o_self_refresh = (state_r == ST_SR);

	// ==========================================================
	// Checks
	logic iss_r;
	logic [11:0] pu_ck_r;
	logic [7:0] dll_ck_r;
	logic [7:0] srx_ck_r;
	logic [1:0] wr_ba_r;

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			iss_r <= 1'b0;
			pu_ck_r <= 12'h000;
			dll_ck_r <= 8'h00;
			srx_ck_r <= 8'hFF;
			wr_ba_r <= 2'h0;
		end
		else
		begin
			iss_r <= ck_en;
			if (ck_en && pu_ck_r != 12'hFFF)
				pu_ck_r <= pu_ck_r + 12'h001;
			if (iss_r && cmd_r == CMD_MRS && o_addr[`DDRC_A8])
				dll_ck_r <= 8'h00;
			else if (ck_en && dll_ck_r != 8'hFF)
				dll_ck_r <= dll_ck_r + 8'h01;
			if (state_r == ST_SR)
				srx_ck_r <= 8'h00;
			else if (ck_en && srx_ck_r != 8'hFF)
				srx_ck_r <= srx_ck_r + 8'h01;
			if (iss_r && cmd_r == CMD_WR)
				wr_ba_r <= o_ba;
		end
	end

	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_n);

	chk_pwrup_cke: assert property (
		o_cke |-> pu_ck_r >= 12'(`DDRC_PWRUP_CK))
		else $error("CKE raised before power-up wait");
	chk_emrs_dll: assert property (
		iss_r && cmd_r == CMD_MRS && o_ba == `DDRC_BA_EMODE
		|-> o_addr[0] == 1'b0)
		else $error("extended mode set leaves DLL off");
	chk_dll_lock: assert property (
		iss_r && cmd_r == CMD_PRE && !init_r && state_r == ST_REF
		|-> dll_ck_r >= 8'(`DDRC_DLL_CK))
		else $error("precharge before DLL lock time");
	chk_mrs_final: assert property (
		$rose(init_r)
		|-> $past(cmd_nxt) == CMD_MRS && !o_addr[`DDRC_A8])
		else $error("final mode set has A8 high");
	chk_act_spacing: assert property (
		iss_r && cmd_r == CMD_ACT |-> ##2 cmd_r != CMD_ACT)
		else $error("ACTIVE commands too close");
	chk_wtr_gap: assert property (
		iss_r && cmd_r == CMD_WR
		|-> ##1 !(iss_r && cmd_r == CMD_RD) [*5])
		else $error("READ too soon after write");
	chk_dal_gap: assert property (
		iss_r && cmd_r == CMD_WR
		|-> ##1 !(iss_r && cmd_r == CMD_ACT && o_ba == wr_ba_r) [*7])
		else $error("ACTIVE inside write recovery");
	chk_xsnr_wait: assert property (
		iss_r && cmd_r != CMD_NOP && init_r && state_r != ST_SR
		|-> srx_ck_r >= 8'(`DDRC_XSNR_CK))
		else $error("command too soon after self refresh");
	chk_xsrd_wait: assert property (
		iss_r && cmd_r == CMD_RD |-> srx_ck_r >= 8'(`DDRC_XSRD_CK))
		else $error("READ too soon after self refresh");

	cov_init: cover property ($rose(init_r));
	cov_write: cover property (iss_r && cmd_r == CMD_WR);
	cov_read: cover property (iss_r && cmd_r == CMD_RD);
	cov_sr_exit: cover property ($fell(o_self_refresh));

endmodule
`default_nettype wire

// ===== ddrc_ctrl_tb.sv
// Self-checking testbench of the DDR command controller
`timescale 1ns/100ps
`default_nettype none
`define check_eq(got, exp) \
begin \
	samples_checked++; \
	if ((got) !== (exp)) \
	begin \
		err_total++; \
		$display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp); \
	end \
end
module ddrc_ctrl_tb;
logic clk = 1'b0, rst_n = 1'b0, valid = 1'b0, wr = 1'b0, sr_req = 1'b0;
logic [1:0] bank = 2'h0, temp = 2'h2;
logic [11:0] row = 12'h000;
logic [7:0] col = 8'h00;
logic ready, init_done, in_sr, ck, ck_n, cke, cs_n, ras_n, cas_n, we_n;
logic [1:0] ba;
logic [11:0] addr;
logic [15:0] viol, n_wr, n_rd, n_ar;
logic init_ok;
int err_total = 0, samples_checked = 0;

always #25 clk = ~clk;

ddrc_ctrl ddrc_ctrl_i (.i_ref_clk(clk), .i_rst_n(rst_n),
	.i_req_valid(valid), .i_req_write(wr), .i_req_bank(bank),
	.i_req_row(row), .i_req_col(col), .o_req_ready(ready),
	.i_sr_req(sr_req), .i_temp_range(temp), .o_init_done(init_done),
	.o_self_refresh(in_sr), .o_ck(ck), .o_ck_n(ck_n), .o_cke(cke),
	.o_cs_n(cs_n), .o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n),
	.o_ba(ba), .o_addr(addr));

ddrc_dev_model ddrc_dev_model_i (.i_ck(ck), .i_ck_n(ck_n), .i_cke(cke),
	.i_cs_n(cs_n), .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n),
	.i_ba(ba), .i_addr(addr), .i_temp_range(temp), .o_viol(viol),
	.o_init_ok(init_ok), .o_n_wr(n_wr), .o_n_rd(n_rd), .o_n_ar(n_ar));

// ==========================================================
// Shared tasks
task automatic close_out();
	$display("checks %0d mismatches %0d", samples_checked, err_total);
	if (err_total == 0 && samples_checked > 0)
		$display("All tests passed");
	else
		$display("Some tests failed");
	$finish;
endtask

task automatic do_req(input logic w, input logic [1:0] bk, output time t);
	int n;
	@(negedge clk);
	{valid, wr, bank, row, col} = {1'b1, w, bk, 12'h5A3, 8'hC6};
	n = 0;
	#1;
	while (ready !== 1'b1 && n < 5000)
	begin
		@(negedge clk);
		#1;
		n++;
	end
	t = $time;
	`check_eq(ready, 1'b1)
	@(negedge clk);
	valid = 1'b0;
endtask

// ==========================================================
// Scenarios
task automatic t_init();
	int n;
	n = 0;
	while (init_done !== 1'b1 && n < 8000)
	begin
		@(negedge clk);
		n++;
	end
	repeat (6) @(negedge clk);
	`check_eq(init_done, 1'b1)
	`check_eq($time >= 64'h30D40, 1'b1)
	`check_eq(init_ok, 1'b1)
	`check_eq(viol, 16'h0000)
	$display("test init done");
endtask

task automatic t_access();
	time t0, t1, t2;
	logic [15:0] w0, r0;
	w0 = n_wr;
	r0 = n_rd;
	do_req(1'b1, 2'h0, t0);
	do_req(1'b0, 2'h0, t1);
	`check_eq(t1 - t0 >= 64'h1F4, 1'b1)
	for (int k = 1; k < 4; k++)
		do_req(1'b1, k[1:0], t2);
	do_req(1'b0, 2'h3, t2);
	repeat (20) @(negedge clk);
	`check_eq(n_wr - w0, 16'h0004)
	`check_eq(n_rd - r0, 16'h0002)
	`check_eq(viol, 16'h0000)
	$display("test access done");
endtask

task automatic t_refresh();
	logic [15:0] a0;
	int lim;
	for (int r = 0; r < 4; r++)
	begin
		@(negedge clk);
		temp = r[1:0];
		lim = (r == 0) ? 1950 : (r == 1) ? 3900 : 7800;
		repeat (200) @(negedge clk);
		a0 = n_ar;
		repeat (800) @(negedge clk);
		`check_eq(n_ar - a0 >= 40000 / lim - 1, 1'b1)
		`check_eq(n_ar - a0 <= 40000 / lim + 2, 1'b1)
	end
	`check_eq(viol, 16'h0000)
	$display("test refresh done");
endtask

task automatic t_self_ref();
	time t0, t1, t2;
	int n;
	@(negedge clk);
	sr_req = 1'b1;
	n = 0;
	while (in_sr !== 1'b1 && n < 400)
	begin
		@(negedge clk);
		n++;
	end
	repeat (4) @(negedge clk);
	`check_eq({in_sr, cke}, 2'h2)
	repeat (300) @(negedge clk);
	sr_req = 1'b0;
	t0 = $time;
	do_req(1'b1, 2'h1, t1);
	do_req(1'b0, 2'h2, t2);
	`check_eq(t1 - t0 >= 7300, 1'b1)
	`check_eq(t2 - t0 >= 19800, 1'b1)
	repeat (20) @(negedge clk);
	`check_eq(viol, 16'h0000)
	$display("test self refresh done");
endtask

// ==========================================================
// Main sequence and watchdog
initial
begin
	repeat (6) @(negedge clk);
	`check_eq({ck, ck_n, cke, ready, init_done}, 5'h08)
	`check_eq({cs_n, ras_n, cas_n, we_n}, 4'h7)
	rst_n = 1'b1;
	t_init();
	t_access();
	t_refresh();
	t_self_ref();
	close_out();
end

initial
begin
	#1000000;
	err_total++;
	close_out();
end
endmodule
`default_nettype wire

// ===== ddrc_dev_model.sv
// Behavioural DDR device that counts command spacing and start-up faults
`timescale 1ns/100ps
`default_nettype none
module ddrc_dev_model
	import ddrc_pkg::*;
(
	input wire logic i_ck, // Device clock
	input wire logic i_ck_n, // Device clock, inverted
	input wire logic i_cke, // Clock enable
	input wire logic i_cs_n, // Chip select, active low
	input wire logic i_ras_n, // Row strobe, active low
	input wire logic i_cas_n, // Column strobe, active low
	input wire logic i_we_n, // Write enable, active low
	input wire logic [1:0] i_ba, // Bank address
	input wire logic [11:0] i_addr, // Address
	input wire logic [1:0] i_temp_range, // Temperature range
	output var logic [15:0] o_viol, // Faults seen
	output var logic o_init_ok, // Start-up order completed
	output var logic [15:0] o_n_wr, // WRITE count
	output var logic [15:0] o_n_rd, // READ count
	output var logic [15:0] o_n_ar // AUTO REFRESH count
);
time t_act[4], t_free[4];
time t_rrd, t_ar, t_mrs, t_wr, t_e, t_0, t_r0, now, tck, lim;
logic [3:0] op, cmd;
logic [1:0] tq;
logic cke_q, in_sr, ok;
int step, sr_n, dll_n, n_i, b;

initial
begin
	{o_viol, o_n_wr, o_n_rd, o_n_ar, o_init_ok} = '0;
	{t_rrd, t_ar, t_mrs, t_wr, t_e, t_0, t_r0} = '0;
	t_act = '{default: 0};
	t_free = '{default: 0};
	{op, tq, cke_q, in_sr} = '0;
	{step, dll_n, n_i} = '0;
	sr_n = 1000;
end

// ==========================================================
// Command decode
task automatic exec();
	if (sr_n < 75 || (sr_n < 200 && cmd == CMD_RD))
		o_viol++;
	if (now - t_mrs < 10)
		o_viol++;
	if (step < 8)
	begin
		case (step)
			1: ok = cmd == CMD_PRE && i_addr[10];
			2: ok = cmd == CMD_MRS && b == 1 && !i_addr[0];
			3: ok = cmd == CMD_MRS && b == 0 && i_addr[8];
			4: ok = cmd == CMD_PRE && i_addr[10] && dll_n >= 200;
			5, 6: ok = cmd == CMD_AR;
			default: ok = cmd == CMD_AR || (cmd == CMD_MRS && !i_addr[8]);
		endcase
		if (!ok)
			o_viol++;
		if (step == 3)
			dll_n = 0;
		if (!(step == 7 && cmd == CMD_AR))
			step++;
		o_init_ok = step == 8;
	end
	case (cmd)
		CMD_MRS: t_mrs = now;
		CMD_ACT:
		begin
			if (now - t_rrd < 10 || now - t_ar < 70 || now < t_free[b])
				o_viol++;
			if (op[b] || now - t_act[b] < 55)
				o_viol++;
			op[b] = 1'b1;
			t_act[b] = now;
			t_rrd = now;
		end
		CMD_RD, CMD_WR:
		begin
			if (!op[b] || now - t_act[b] < 15)
				o_viol++;
			op[b] = !i_addr[10];
			if (cmd == CMD_WR)
			begin
				t_wr = now;
				o_n_wr++;
				t_free[b] = now + (2 + 2 * ((15 + tck - 1) / tck)) * tck;
			end
			else
			begin
				if (now < t_wr + 2 * tck + 10 || now + tck - t_act[b] < 40)
					o_viol++;
				t_free[b] = now + tck + 15;
				o_n_rd++;
			end
		end
		CMD_PRE:
			for (int i = 0; i < 4; i++)
				if (i_addr[10] || i == b)
				begin
					op[i] = 1'b0;
					t_free[i] = now + 15;
				end
		CMD_AR:
		begin
			if (now - t_ar < 70 || op != 4'h0)
				o_viol++;
			t_ar = now;
			o_n_ar++;
			if (step < 8 || t_r0 == 0)
			begin
				t_r0 = now;
				n_i = 0;
			end
			else
				n_i++;
		end
		default: o_viol++;
	endcase
endtask

// ==========================================================
// Clock edge
always @(posedge i_ck)
begin
	now = $time;
	tck = now - t_e;
	t_e = now;
	if (t_0 == 0)
		t_0 = now;
	cmd = {i_cs_n, i_ras_n, i_cas_n, i_we_n};
	b = i_ba;
	lim = (i_temp_range == 2'h0) ? 1950 : (i_temp_range == 2'h1) ? 3900 : 7800;
	sr_n++;
	dll_n++;
	if (i_ck_n !== 1'b0)
		o_viol++;
	if (i_temp_range != tq || in_sr)
		t_r0 = 0;
	tq = i_temp_range;
	if (step == 8 && t_r0 != 0 && now - t_r0 > (n_i + 1) * lim + 5 * tck)
		o_viol++;
	if (!i_cke && step == 0 && cmd != CMD_NOP)
		o_viol++;
	if (i_cke && !cke_q)
	begin
		if (cmd != CMD_NOP)
			o_viol++;
		if (in_sr)
			sr_n = 0;
		else if (step == 0 && now - t_0 < 200000)
			o_viol++;
		if (step == 0)
			step = 1;
		in_sr = 1'b0;
	end
	if (!i_cke && cke_q && cmd == CMD_AR)
		in_sr = 1'b1;
	if (i_cke && cke_q && cmd != CMD_NOP)
		exec();
	cke_q = i_cke;
end
endmodule
`default_nettype wire

// ===== ddrc_pkg.sv
// Types of the DDR command controller
package ddrc_pkg;

	// ==========================================================
	// Command codes {cs_n, ras_n, cas_n, we_n}
	typedef enum logic [3:0] {
		CMD_MRS = 4'h0,
		CMD_AR = 4'h1,
		CMD_PRE = 4'h2,
		CMD_ACT = 4'h3,
		CMD_WR = 4'h4,
		CMD_RD = 4'h5,
		CMD_NOP = 4'h7
	} ddrc_cmd_t;

	// ==========================================================
	// Sequencer states
	typedef enum logic [3:0] {
		ST_PWRUP = 4'h0,
		ST_PRE1 = 4'h1,
		ST_EMRS = 4'h2,
		ST_MRS_DLL = 4'h3,
		ST_PRE2 = 4'h4,
		ST_REF = 4'h5,
		ST_MRS_OP = 4'h6,
		ST_IDLE = 4'h7,
		ST_RW = 4'h8,
		ST_SR = 4'h9
	} ddrc_state_t;

endpackage
